/* File: distributed_dma_slave.sv */
`timescale 1ns/1ps
`include "distributed_dma_slave_cfg.svh"
// Behaviour
// RULE1: Registers decode in a 16-byte I/O window based on config bits 15-4.
// RULE2: Reserved offsets read zero and writes to them do nothing.
// RULE3: Obsolete legacy bits are read-only with no function.
// RULE4: Address write sets start address; read returns current address.
// RULE5: Byte mode drives address on AD15-0 and page on AD23-16.
// RULE6: Word mode drives address on AD16-1, AD0 zero, page 7-1 on AD23-17.
// RULE7: Page register is read/write and supplies the upper address byte.
// RULE8: Count write sets length; read returns remaining count.
// RULE9: Each transfer decrements count by one in byte mode, two in word mode.
// RULE10: Command bit 2 set disables the slave; reset zero; other bits zero.
// RULE11: Status bits 7-4 follow the card DMA request.
// RULE12: Request status ignores the mask bit.
// RULE13: Status bits 3-0 set at terminal count, clear on status read or reset.
// RULE14: Offset 08h reads status and writes command.
// RULE15: Mode bits 7-6 select transfer mode, bit 5 selects address decrement.
// RULE16: Mode bits 3-2 select transfer type, bit 4 enables auto reload.
// RULE17: Mask bit 0 ignores card requests, resets to one, sets on card removal.
// RULE18: Any write to offset 0Dh resets slave and all registers.
module distributed_dma_slave
(
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic [15:0]         io_addr,
  input  wire logic                io_valid,
  input  wire logic                io_write,
  input  wire logic [7:0]          io_wdata,
  input  wire logic [15:0]         dma_base_cfg,
  output logic      [7:0]          io_rdata,
  output logic                     io_hit,
  input  wire logic                card_dma_request,
  input  wire logic                card_removed,
  input  wire logic                wide_mode,
  input  wire logic                xfer_done,
  output logic                     dma_request_out,
  output logic                     slave_enabled,
  output distributed_dma_slave_pkg::mode_type       mode,
  output logic      [23:0]         pci_ad
);
  import distributed_dma_slave_pkg::*;

  io_req_type  req;
  logic [15:0] addr_ff, base_addr_ff, count_ff, base_count_ff;
  logic [15:0] nxt_addr, nxt_base_addr, nxt_count, nxt_base_count;
  logic [7:0]  page_ff, nxt_page;
  logic        disable_ff, nxt_disable;
  logic        term_ff, nxt_term;
  logic        mask_ff, nxt_mask;
  mode_type    mode_ff, nxt_mode;
  logic [1:0]  pin_raw, pin_seen;
  logic        card_req_seen, removed_seen;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        mclear;
  logic [15:0] step;

  // Window match on bits 15-4 of the configured base.
  assign io_hit = io_valid &&
                  (io_addr[15:`BASE_LSB] == dma_base_cfg[15:`BASE_LSB]); // [RULE1]
  assign req = '{valid: io_hit, write: io_write, offset: io_addr[3:0], wdata: io_wdata};
  assign mclear = req.valid && req.write && (req.offset == `OFS_MCLEAR); // [RULE18]
  assign step = wide_mode ? 16'h0002 : 16'h0001;

  assign pin_raw = {card_removed, card_dma_request};

  // Card pins are asynchronous; a change is accepted when stages two and three agree.
  // Waiting for agreement keeps a metastable second stage from ever being taken alone.
  for (genvar g = 0; g < 2; g++)
  begin : g_pin_sync
    logic [2:0] sync_ff;
    logic       seen_ff, nxt_seen;
    always_comb
    begin
      nxt_seen = (sync_ff[2] == sync_ff[1]) ? sync_ff[1] : seen_ff;
    end
    always_ff @(posedge mclk or negedge nrst)
    begin
      if (!nrst)
      begin
        sync_ff <= 3'h0;
        seen_ff <= 1'b0;
      end
      else
      begin
        sync_ff <= {sync_ff[1:0], pin_raw[g]};
        seen_ff <= nxt_seen;
      end
    end
    assign pin_seen[g] = seen_ff;
  end
  assign card_req_seen = pin_seen[0];
  assign removed_seen  = pin_seen[1];

  always_comb
  begin
    nxt_addr       = addr_ff;
    nxt_base_addr  = base_addr_ff;
    nxt_count      = count_ff;
    nxt_base_count = base_count_ff;
    nxt_page       = page_ff;
    nxt_disable    = disable_ff;
    nxt_mode       = mode_ff;
    nxt_mask       = mask_ff;
    nxt_term       = term_ff;
    nxt_rdata      = 8'h00;
    // A transfer ending on the same edge as a software write other than master clear loses only the address or count byte that the write sets.
    if (xfer_done && !disable_ff)
    begin
      nxt_count = count_ff - step; // [RULE9]
      nxt_addr  = mode_ff.address_direction_bit ? addr_ff - step : addr_ff + step;
      if (count_ff <= step)
      begin
        if (mode_ff.auto_reload_enable)
        begin
          nxt_count = base_count_ff;
          nxt_addr  = base_addr_ff;
        end
        nxt_term = 1'b1; // [RULE13]
      end
    end
    if (req.valid && !req.write)
    begin
      case (req.offset)
        `OFS_ADDRESS:    nxt_rdata = addr_ff[7:0]; // [RULE4]
        `OFS_ADDRESS_HI: nxt_rdata = addr_ff[15:8];
        `OFS_PAGE:       nxt_rdata = page_ff; // [RULE7]
        `OFS_COUNT:      nxt_rdata = count_ff[7:0]; // [RULE8]
        `OFS_COUNT_HI:   nxt_rdata = count_ff[15:8];
        `OFS_CMD_STATUS:
        begin
          nxt_rdata = {{4{card_req_seen}}, {4{term_ff}}}; // [RULE14] [RULE11] [RULE12] [RULE13]
          nxt_term  = 1'b0; // [RULE13]
        end
        `OFS_MODE:       nxt_rdata = {mode_ff, 2'b00}; // [RULE3]
        `OFS_MASK:       nxt_rdata = {7'h00, mask_ff};
        default:         nxt_rdata = 8'h00; // [RULE2]
      endcase
    end
    if (req.valid && req.write)
    begin
      case (req.offset)
        `OFS_ADDRESS:
        begin
          nxt_addr[7:0]      = req.wdata; // [RULE4]
          nxt_base_addr[7:0] = req.wdata;
        end
        `OFS_ADDRESS_HI:
        begin
          nxt_addr[15:8]      = req.wdata;
          nxt_base_addr[15:8] = req.wdata;
        end
        `OFS_PAGE:       nxt_page = req.wdata; // [RULE7]
        `OFS_COUNT:
        begin
          nxt_count[7:0]      = req.wdata; // [RULE8]
          nxt_base_count[7:0] = req.wdata;
        end
        `OFS_COUNT_HI:
        begin
          nxt_count[15:8]      = req.wdata;
          nxt_base_count[15:8] = req.wdata;
        end
        `OFS_CMD_STATUS: nxt_disable = req.wdata[`CMD_DISABLE_POS]; // [RULE10] [RULE14]
        `OFS_MODE:       nxt_mode = mode_type'(req.wdata[7:2]); // [RULE15] [RULE16]
        `OFS_MASK:       nxt_mask = req.wdata[0]; // [RULE17]
        default:         nxt_mask = nxt_mask; // [RULE2]
      endcase
    end
    // Removal wins over a software clear so a pulled card never raises requests.
    if (removed_seen)
      nxt_mask = 1'b1; // [RULE17]
    // Master clear overrides everything, a transfer ending on the same edge included.
    if (mclear)
    begin
      nxt_addr       = 16'h0000; // [RULE18]
      nxt_base_addr  = 16'h0000;
      nxt_count      = 16'h0000;
      nxt_base_count = 16'h0000;
      nxt_page       = 8'h00;
      nxt_disable    = 1'b0;
      nxt_mode       = mode_type'(`MODE_RESET);
      nxt_mask       = `MASK_RESET;
      nxt_term       = 1'b0;
      nxt_rdata      = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_ff       <= 16'h0000;
      base_addr_ff  <= 16'h0000;
      count_ff      <= 16'h0000;
      base_count_ff <= 16'h0000;
      page_ff       <= 8'h00;
      disable_ff    <= 1'b0;
      mode_ff       <= mode_type'(`MODE_RESET);
      mask_ff       <= `MASK_RESET;
      term_ff       <= 1'b0;
      rdata_ff      <= 8'h00;
    end
    else
    begin
      addr_ff       <= nxt_addr;
      base_addr_ff  <= nxt_base_addr;
      count_ff      <= nxt_count;
      base_count_ff <= nxt_base_count;
      page_ff       <= nxt_page;
      disable_ff    <= nxt_disable;
      mode_ff       <= nxt_mode;
      mask_ff       <= nxt_mask;
      term_ff       <= nxt_term;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign io_rdata        = rdata_ff;
  assign slave_enabled   = !disable_ff; // [RULE10]
  assign dma_request_out = card_req_seen && !mask_ff && !disable_ff; // [RULE17]
  assign mode            = mode_ff;

  distributed_dma_slave_addr_gen u_addr_gen
  (
    .mclk (mclk),
    .nrst (nrst),
    .wide (wide_mode),
    .addr (addr_ff),
    .page (page_ff),
    .ad_ff(pci_ad)
  );
endmodule // distributed_dma_slave

/* File: distributed_dma_slave_cfg.svh */
`ifndef DISTRIBUTED_DMA_SLAVE_CFG_SVH
`define DISTRIBUTED_DMA_SLAVE_CFG_SVH
`define OFS_ADDRESS     4'h0
`define OFS_ADDRESS_HI  4'h1
`define OFS_PAGE        4'h2
`define OFS_COUNT       4'h4
`define OFS_COUNT_HI    4'h5
`define OFS_CMD_STATUS  4'h8
`define OFS_MODE        4'hb
`define OFS_MCLEAR      4'hd
`define OFS_MASK        4'hf
`define BASE_LSB        4
`define CMD_DISABLE_POS 2
`define MASK_RESET      1'b1
`define MODE_RESET      6'h00
`endif

/* File: distributed_dma_slave_pkg.sv */
package distributed_dma_slave_pkg;
  typedef enum logic [1:0] {xfer_demand = 2'b00, xfer_single = 2'b01,
                            xfer_block = 2'b10, xfer_rsvd = 2'b11} transfer_mode_type;
  typedef enum logic [1:0] {type_none = 2'b00, type_write = 2'b01,
                            type_read = 2'b10, type_bad = 2'b11} transfer_type_type;
  typedef struct packed {
    transfer_mode_type transfer_mode_select;
    logic              address_direction_bit;
    logic              auto_reload_enable;
    transfer_type_type transfer_type_select;
  } mode_type;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] offset;
    logic [7:0] wdata;
  } io_req_type;
endpackage

/* File: distributed_dma_slave_addr_gen.sv */
`timescale 1ns/1ps
// Forms the address-phase word from current address and page for either transfer width.
module distributed_dma_slave_addr_gen
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        wide,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  page,
  output logic      [23:0] ad_ff
);
  logic [23:0] nxt_ad;
  always_comb
  begin
    if (wide)
      nxt_ad = {page[7:1], addr, 1'b0}; // [RULE6]
    else
      nxt_ad = {page, addr}; // [RULE5]
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ad_ff <= 24'h000000;
    else
      ad_ff <= nxt_ad;
  end
endmodule // distributed_dma_slave_addr_gen

/* File: distributed_dma_slave_sva.sv */
`timescale 1ns/1ps
module distributed_dma_slave_slave_sva
(
  input wire logic               mclk,
  input wire logic               nrst,
  input wire logic [15:0]        io_addr,
  input wire logic               io_valid,
  input wire logic               io_write,
  input wire logic [7:0]         io_wdata,
  input wire logic [15:0]        dma_base_cfg,
  input wire logic [7:0]         io_rdata,
  input wire logic               io_hit,
  input wire logic               card_removed,
  input wire logic               wide_mode,
  input wire logic               xfer_done,
  input wire logic               dma_request_out,
  input wire logic               slave_enabled,
  input wire distributed_dma_slave_pkg::mode_type mode,
  input wire logic [23:0]        pci_ad
);
  import distributed_dma_slave_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic [3:0] ofs = io_addr[3:0];
  sequence rd8;
    io_hit && !io_write && ofs == 4'h8;
  endsequence
  a_hit_decode: assert property (
    io_hit == (io_valid && io_addr[15:4] == dma_base_cfg[15:4])) else $error("decode wrong");
  a_rsvd_zero: assert property (
    io_hit && !io_write && ofs inside {4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'he}
    |=> io_rdata == 8'h00) else $error("reserved read not zero");
  a_cmd_enable: assert property (
    io_hit && io_write && ofs == 4'h8 |=> slave_enabled == !$past(io_wdata[2]))
    else $error("command write wrong");
  a_status_form: assert property (
    rd8 |=> io_rdata[7:4] inside {4'h0, 4'hf} && io_rdata[3:0] inside {4'h0, 4'hf})
    else $error("status nibbles split");
  a_status_clear: assert property (
    rd8 ##1 !xfer_done ##1 rd8 |=> io_rdata[3:0] == 4'h0) else $error("count flag kept");
  a_mode_write: assert property (
    io_hit && io_write && ofs == 4'hb |=> mode == $past(io_wdata[7:2]))
    else $error("mode write wrong");
  a_mclear_all: assert property (
    io_hit && io_write && ofs == 4'hd |=> slave_enabled && mode == 6'h00 && !dma_request_out)
    else $error("master clear incomplete");
  a_removed_mask: assert property (
    card_removed [*6] |-> !dma_request_out) else $error("request with card gone");
  a_req_gate: assert property (
    dma_request_out |-> slave_enabled) else $error("request while disabled");
  a_word_ad0: assert property (
    wide_mode [*2] |-> pci_ad[0] == 1'b0) else $error("word address bit 0 set");
endmodule // distributed_dma_slave_slave_sva

/* File: distributed_dma_slave_master_model.sv */
`timescale 1ns/1ps
// Stands in for the PCI master: each pulse call completes one transfer.
module distributed_dma_slave_master_model
(
  input  wire logic mclk,
  output logic      xfer_done
);
  initial xfer_done = 1'b0;
  // Launched on the falling edge so the slave always samples a settled level.
  task automatic pulse;
    @(negedge mclk);
    xfer_done = 1'b1;
    @(negedge mclk);
    xfer_done = 1'b0;
  endtask
endmodule // distributed_dma_slave_master_model

/* File: distributed_dma_slave_regs_bench.sv */
`timescale 1ns/1ps
module distributed_dma_slave_regs_bench;
  import distributed_dma_slave_pkg::*;
  logic        mclk, nrst, io_valid, io_write, card_dma_request, card_removed, wide_mode;
  logic        io_hit, xfer_done, dma_request_out, slave_enabled;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0]  io_wdata = 8'h00, io_rdata, rd;
  logic [23:0] pci_ad;
  mode_type    mode;
  int          error_cnt = 0, n_tests = 0, cyc = 0;
  logic [15:0] dma_base = 16'h0340;
  // Each row is offset, write byte, expected read back.
  logic [19:0] rows [11] = '{20'h0a5a5, 20'h13c3c, 20'h27e7e, 20'h41111, 20'h52222,
    20'h6ff00, 20'h7ff00, 20'h9ff00, 20'haff00, 20'hcff00, 20'heff00};
  distributed_dma_slave i_dut (.mclk(mclk), .nrst(nrst), .io_addr(io_addr),
    .io_valid(io_valid), .io_write(io_write), .io_wdata(io_wdata), .dma_base_cfg(dma_base),
    .io_rdata(io_rdata), .io_hit(io_hit), .card_dma_request(card_dma_request),
    .card_removed(card_removed), .wide_mode(wide_mode), .xfer_done(xfer_done),
    .dma_request_out(dma_request_out), .slave_enabled(slave_enabled), .mode(mode),
    .pci_ad(pci_ad));
  distributed_dma_slave_master_model i_master (.mclk(mclk), .xfer_done(xfer_done));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic io(input logic [3:0] ofs, input logic wr, input logic [7:0] d);
    @(negedge mclk);
    io_addr = {dma_base[15:4], ofs};
    io_write = wr;
    io_wdata = d;
    io_valid = 1'b1;
    @(negedge mclk);
    io_valid = 1'b0;
    rd = io_rdata;
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // A hang shows up as a cycle ceiling well above the roughly two hundred cycles needed.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  initial
  begin
    {nrst, io_valid, io_write, card_dma_request, card_removed, wide_mode} = 6'h00;
    repeat (5) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    check(slave_enabled, 1);
    foreach (rows[i])
    begin
      io(rows[i][19:16], 0, 8'h00);
      check(rd, 0);
    end
    foreach (rows[i])
    begin
      io(rows[i][19:16], 1, rows[i][15:8]);
      io(rows[i][19:16], 0, 8'h00);
      check(rd, rows[i][7:0]);
    end
    @(negedge mclk);
    io_addr = 16'h0448;
    io_wdata = 8'h04;
    {io_valid, io_write} = 2'b11;
    #1 check(io_hit, 0);
    @(negedge mclk) io_valid = 1'b0;
    check(slave_enabled, 1);
    dma_base = 16'h044c;
    io(4'h2, 0, 8'h00);
    check(rd, 8'h7e);
    dma_base = 16'h0340;
    io(4'h0, 1, 8'h34);
    io(4'h1, 1, 8'h12);
    io(4'h2, 1, 8'h56);
    @(negedge mclk) check(pci_ad, 24'h561234);
    wide_mode = 1'b1;
    @(negedge mclk) check(pci_ad, {7'h2b, 16'h1234, 1'b0});
    io(4'h4, 1, 8'h03);
    io(4'h5, 1, 8'h00);
    wide_mode = 1'b0;
    i_master.pulse();
    io(4'h4, 0, 8'h00);
    check(rd, 8'h02);
    io(4'h0, 0, 8'h00);
    check(rd, 8'h35);
    wide_mode = 1'b1;
    i_master.pulse();
    io(4'h4, 0, 8'h00);
    check(rd, 8'h00);
    io(4'h0, 0, 8'h00);
    check(rd, 8'h37);
    io(4'h8, 0, 8'h00);
    check(rd, 8'h0f);
    io(4'h8, 0, 8'h00);
    check(rd, 8'h00);
    io(4'h8, 1, 8'hff);
    check(slave_enabled, 0);
    io(4'h8, 0, 8'h00);
    check(rd, 8'h00);
    io(4'h8, 1, 8'h00);
    io(4'hf, 1, 8'h00);
    card_dma_request = 1'b1;
    repeat (5) @(negedge mclk);
    check(dma_request_out, 1);
    io(4'h8, 0, 8'h00);
    check(rd, 8'hf0);
    io(4'hf, 1, 8'h01);
    io(4'hf, 0, 8'h00);
    check(rd, 8'h01);
    check(dma_request_out, 0);
    io(4'h8, 0, 8'h00);
    check(rd, 8'hf0);
    io(4'hf, 1, 8'h00);
    card_removed = 1'b1;
    repeat (7) @(negedge mclk);
    check(dma_request_out, 0);
    {card_removed, card_dma_request} = 2'b00;
    repeat (5) @(negedge mclk);
    io(4'h8, 0, 8'h00);
    check(rd, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      io(4'hb, 1, {k[1:0], k[0], ~k[0], k[1:0], 2'b11});
      check(mode, {k[1:0], k[0], ~k[0], k[1:0]});
      io(4'hb, 0, 8'h00);
      check(rd, {k[1:0], k[0], ~k[0], k[1:0], 2'b00});
    end
    wide_mode = 1'b0;
    io(4'hb, 1, 8'h30);
    io(4'h0, 1, 8'h10);
    io(4'h1, 1, 8'h00);
    io(4'h4, 1, 8'h02);
    io(4'h5, 1, 8'h00);
    i_master.pulse();
    io(4'h0, 0, 8'h00);
    check(rd, 8'h0f);
    i_master.pulse();
    io(4'h4, 0, 8'h00);
    check(rd, 8'h02);
    io(4'h0, 0, 8'h00);
    check(rd, 8'h10);
    io(4'h8, 0, 8'h00);
    check(rd, 8'h0f);
    io(4'h2, 1, 8'h99);
    nrst = 1'b0;
    @(negedge mclk) nrst = 1'b1;
    io(4'h2, 0, 8'h00);
    check(rd, 8'h00);
    io(4'hf, 0, 8'h00);
    check(rd, 8'h01);
    io(4'h2, 1, 8'h66);
    io(4'h8, 1, 8'h04);
    io(4'hd, 1, 8'h5a);
    check({slave_enabled, mode}, 7'h40);
    io(4'h2, 0, 8'h00);
    check(rd, 8'h00);
    stop_test();
  end
endmodule // distributed_dma_slave_regs_bench
bind distributed_dma_slave distributed_dma_slave_slave_sva i_sva (.mclk(mclk), .nrst(nrst),
  .io_addr(io_addr), .io_valid(io_valid), .io_write(io_write), .io_wdata(io_wdata),
  .dma_base_cfg(dma_base_cfg), .io_rdata(io_rdata), .io_hit(io_hit),
  .card_removed(card_removed), .wide_mode(wide_mode), .xfer_done(xfer_done),
  .dma_request_out(dma_request_out), .slave_enabled(slave_enabled), .mode(mode),
  .pci_ad(pci_ad));
